// ---- hdl/epp_cycle_engine.sv ----
// EPP cycle engine top: registers, handshake sequencer, pin muxing
`timescale 1ns/1ps
module epp_cycle_engine #(
	parameter int TMO_CYC = epp_pkg::EPP_TMO_CYC
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic [2:0]  hsize,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Peripheral inputs
	input  wire logic        periph_ready_n,
	input  wire logic [7:0]  port_byte_in,
	input  wire logic        periph_irq_in,
	input  wire logic        err_n_in,
	input  wire logic        slct_in,
	input  wire logic        pe_in,
	input  wire logic        ack_n_in,
	input  wire logic        busy_in,
	// Peripheral outputs
	output logic [7:0]       port_byte_bus,
	output logic             port_byte_oe_n,
	output logic             data_strobe_n,
	output logic             addr_strobe_n,
	output logic             xfer_dir_out_n,
	output logic             autofd_n,
	output logic             printer_select_ctl,
	output logic             periph_reset_n,
	output logic             periph_irq_out
);
	import epp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Bus front end

	logic       dp_valid;
	logic       dp_write;
	logic [7:0] dp_off;

	epp_ahb_if u_bus (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.hsel     (hsel),
		.haddr    (haddr),
		.htrans   (htrans),
		.hwrite   (hwrite),
		.hready   (hready),
		.dp_valid (dp_valid),
		.dp_write (dp_write),
		.dp_off   (dp_off)
	);

	////////////////////////////////////////////////////////////////////////////
	// Registers and state

	logic [7:0] data_r;
	logic [5:0] ctrl_r;
	logic [7:0] mode_r;
	logic       cycle_timeout_flag_r;
	logic [7:0] rbyte_r;
	logic       wait_hold_r;
	epp_state_t st_r;
	epp_state_t st_nxt;
	epp_req_t   req_r;
	epp_req_t   req_new;
	epp_req_t   req_use;
	epp_pins_t  pins_r;
	epp_pins_t  pins_nxt;
	logic       irq_r;
	logic       expired;

	// Offsets in the EPP window start an engine cycle
	function automatic logic epp_off_f(input logic [7:0] off);
		return (off == EPP_OFF_ADDR) || ((off >= EPP_OFF_DATA0) && (off <= EPP_OFF_DATA3));
	endfunction : epp_off_f

	wire is_epp_off  = epp_off_f(dp_off);
	wire epp_en      = mode_r[EPP_MD_EN];
	wire v17         = mode_r[EPP_MD_V17];
	// Stall raised in the address phase, so the access itself waits
	wire ap_take     = hsel && hready && htrans[1];
	wire [7:0] ap_off = haddr[7:0];
	wire ap_epp      = ap_take && epp_off_f(ap_off) && epp_en;
	wire ap_rd       = ap_take && !hwrite;
	// One start per stalled access, never again on the closing edge
	wire start       = dp_valid && is_epp_off && wait_hold_r && (st_r == EPP_IDLE);
	wire busy        = (st_r != EPP_IDLE);
	wire reg_wr      = dp_valid && dp_write && !is_epp_off;
	wire reg_rd      = dp_valid && !dp_write && !is_epp_off;
	wire [7:0] wdata_w = hwdata[7:0];
	wire rdy_hi      = periph_ready_n;
	wire ctl_strobe  = ctrl_r[EPP_CT_STROBE];
	wire cyc_write   = v17 ? !ctrl_r[EPP_CT_DIR] : req_use.is_write;
	wire st_rd_end   = reg_rd && (dp_off == EPP_OFF_STATUS);
	wire tmo_wr_clr  = reg_wr && (dp_off == EPP_OFF_STATUS) && hwdata[EPP_ST_CYCLE_TIMEOUT_FLAG]
	                && !mode_r[EPP_MD_TOSEL];
	wire tmo_rd_clr  = st_rd_end && mode_r[EPP_MD_TOSEL];
	wire finish      = (st_r == EPP_DONE);

	// A 1.7 cycle strobes on the start edge, before req_r has loaded
	assign req_new = '{is_addr: (dp_off == EPP_OFF_ADDR), is_write: dp_write, wbyte: wdata_w};
	assign req_use = start ? req_new : req_r;

	epp_wdog #(.LIMIT(TMO_CYC), .W(EPP_TMO_W)) u_wdog (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (busy && !finish),
		.expired (expired)
	);

	////////////////////////////////////////////////////////////////////////////
	// Handshake sequencer

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			EPP_IDLE:  if (start) st_nxt = v17 ? EPP_STRB : EPP_ARM;
			EPP_ARM:   if (!rdy_hi) st_nxt = EPP_SETUP;
			EPP_SETUP: st_nxt = EPP_STRB;
			EPP_STRB:  if (rdy_hi) st_nxt = EPP_DONE;
			EPP_DONE:  st_nxt = EPP_IDLE;
			default:   st_nxt = EPP_IDLE;
		endcase
		if (expired) st_nxt = EPP_DONE;
	end

	// Pin values: idle follows control register, cycle follows sequencer
	always_comb begin
		pins_nxt.data_strobe_n  = 1'b1;
		pins_nxt.addr_strobe_n  = 1'b1;
		pins_nxt.xfer_dir_out_n = 1'b1;
		pins_nxt.bus_oe_n       = ctrl_r[EPP_CT_DIR];
		pins_nxt.port_byte_out  = data_r;
		if (st_nxt != EPP_IDLE && st_nxt != EPP_ARM) begin
			pins_nxt.port_byte_out  = req_use.wbyte;
			pins_nxt.bus_oe_n       = !cyc_write;
			pins_nxt.xfer_dir_out_n = !cyc_write;
			if (st_nxt == EPP_STRB) begin
				pins_nxt.data_strobe_n = req_use.is_addr;
				pins_nxt.addr_strobe_n = !req_use.is_addr;
			end
			if (ctl_strobe) begin
				pins_nxt.bus_oe_n       = 1'b0;
				pins_nxt.xfer_dir_out_n = 1'b0;
			end
		end else if (st_nxt == EPP_ARM) begin
			pins_nxt.port_byte_out = pins_r.port_byte_out;
			pins_nxt.bus_oe_n      = pins_r.bus_oe_n;
			pins_nxt.xfer_dir_out_n = pins_r.xfer_dir_out_n;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r   <= EPP_IDLE;
			req_r  <= '0;
			pins_r <= '{1'b1, 1'b1, 1'b1, 1'b1, 8'h00};
		end else begin
			st_r   <= st_nxt;
			pins_r <= pins_nxt;
			if (start) begin
				req_r <= req_new;
			end
		end
	end

	// Capture byte while strobe still low, on ready high
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rbyte_r <= 8'h00;
		end else if (st_r == EPP_STRB && rdy_hi) begin
			rbyte_r <= port_byte_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Software registers

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_r  <= 8'h00;
			ctrl_r  <= EPP_CTRL_RST;
			mode_r  <= 8'h00;
			cycle_timeout_flag_r <= 1'b0;
		end else begin
			if (reg_wr && dp_off == EPP_OFF_DATA) data_r <= hwdata[7:0];
			if (reg_wr && dp_off == EPP_OFF_CTRL) ctrl_r <= hwdata[5:0];
			if (reg_wr && dp_off == EPP_OFF_MODE) mode_r <= hwdata[7:0];
			// Set wins over clear so no timeout is lost
			if (expired) cycle_timeout_flag_r <= 1'b1;
			else if (tmo_wr_clr || tmo_rd_clr) cycle_timeout_flag_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus answer: wait states held until the cycle finishes

	logic [7:0] rd_mux;
	// Loaded in the address phase so hrdata stands through the data phase
	assign rd_mux = (ap_off == EPP_OFF_DATA)   ? data_r :
	                (ap_off == EPP_OFF_STATUS) ? {!busy_in, ack_n_in, pe_in, slct_in,
	                                              err_n_in, 2'b00, cycle_timeout_flag_r} :
	                (ap_off == EPP_OFF_CTRL)   ? {2'b00, ctrl_r} :
	                (ap_off == EPP_OFF_MODE)   ? mode_r : 8'h00;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout   <= 1'b1;
			hrdata      <= 32'h0000_0000;
			wait_hold_r <= 1'b0;
		end else begin
			if (ap_epp) begin
				hreadyout   <= 1'b0;
				wait_hold_r <= 1'b1;
			end else if (wait_hold_r && finish) begin
				hreadyout   <= 1'b1;
				wait_hold_r <= 1'b0;
				hrdata      <= {24'h000000, (st_r == EPP_DONE) ? rbyte_r : 8'h00};
			end else if (ap_rd) begin
				hrdata <= {24'h000000, rd_mux};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pass-through pins

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_r              <= 1'b0;
			autofd_n           <= 1'b1;
			printer_select_ctl <= 1'b1;
			periph_reset_n     <= 1'b0;
		end else begin
			irq_r              <= periph_irq_in;
			autofd_n           <= !ctrl_r[EPP_CT_AUTOFD];
			printer_select_ctl <= !ctrl_r[EPP_CT_SELIN];
			periph_reset_n     <= ctrl_r[EPP_CT_INIT];
		end
	end

	assign hresp          = 1'b0;
	assign periph_irq_out = irq_r;
	assign port_byte_bus  = pins_r.port_byte_out;
	assign port_byte_oe_n = pins_r.bus_oe_n;
	assign data_strobe_n  = pins_r.data_strobe_n;
	assign addr_strobe_n  = pins_r.addr_strobe_n;
	assign xfer_dir_out_n = pins_r.xfer_dir_out_n;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	stall_on_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start |=> !hreadyout) else $error("no wait state after cycle start");
	arm_no_strobe_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(st_r == EPP_ARM) |-> (data_strobe_n && addr_strobe_n))
		else $error("strobe moved before ready fell");
	strobe_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(st_r == EPP_STRB && rdy_hi && !expired) |=> (data_strobe_n && addr_strobe_n))
		else $error("strobe not released after ready");
	wdog_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		expired |=> cycle_timeout_flag_r) else $error("timeout flag not set");
	tmo_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(tmo_wr_clr && !expired) |=> !cycle_timeout_flag_r) else $error("timeout flag not cleared");
	idle_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(hresetn && st_r == EPP_IDLE && $stable(ctrl_r))
		|=> (port_byte_oe_n == $past(ctrl_r[EPP_CT_DIR]))
		|| (st_r != EPP_IDLE)) else $error("idle direction not from control");
	force_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(st_r == EPP_STRB && ctl_strobe) |-> (!xfer_dir_out_n && !port_byte_oe_n))
		else $error("strobe bit did not force write");
	irq_pass_a: assert property (@(posedge hclk) disable iff (!hresetn)
		hresetn |=> (periph_irq_out == $past(periph_irq_in))) else $error("interrupt not passed");
	release_ready_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wait_hold_r && finish) |=> hreadyout) else $error("bus not released at end");

endmodule : epp_cycle_engine

// ---- hdl/epp_pkg.sv ----
// Package of constants, types and register map for the EPP cycle engine
package epp_pkg;

	// Register byte offsets
	localparam logic [7:0] EPP_OFF_DATA    = 8'h00;
	localparam logic [7:0] EPP_OFF_STATUS  = 8'h04;
	localparam logic [7:0] EPP_OFF_CTRL    = 8'h08;
	localparam logic [7:0] EPP_OFF_ADDR    = 8'h0c;
	localparam logic [7:0] EPP_OFF_DATA0   = 8'h10;
	localparam logic [7:0] EPP_OFF_DATA3   = 8'h1c;
	localparam logic [7:0] EPP_OFF_MODE    = 8'h20;

	// Status fields
	localparam int EPP_ST_CYCLE_TIMEOUT_FLAG    = 0;
	localparam int EPP_ST_ERR      = 3;
	localparam int EPP_ST_SLCT     = 4;
	localparam int EPP_ST_PE       = 5;
	localparam int EPP_ST_ACK      = 6;
	localparam int EPP_ST_BUSY     = 7;

	// Control fields
	localparam int EPP_CT_STROBE   = 0;
	localparam int EPP_CT_AUTOFD   = 1;
	localparam int EPP_CT_INIT     = 2;
	localparam int EPP_CT_SELIN    = 3;
	localparam int EPP_CT_DIR      = 5;
	localparam logic [5:0] EPP_CTRL_RST = 6'h00;

	// Mode register fields
	localparam int EPP_MD_EN       = 0;
	localparam int EPP_MD_V17      = 1;
	localparam int EPP_MD_TOSEL    = 4;

	// Watchdog timing
	localparam int EPP_CLK_MHZ     = 10;
	localparam int EPP_TMO_US      = 10;
	localparam int EPP_TMO_CYC     = EPP_TMO_US * EPP_CLK_MHZ;
	localparam int EPP_TMO_W       = 8;

	typedef enum logic [2:0] {
		EPP_IDLE  = 3'b000,
		EPP_ARM   = 3'b001,
		EPP_SETUP = 3'b011,
		EPP_STRB  = 3'b010,
		EPP_DONE  = 3'b110
	} epp_state_t;

	// Outputs towards the peripheral
	typedef struct packed {
		logic       data_strobe_n;
		logic       addr_strobe_n;
		logic       xfer_dir_out_n;
		logic       bus_oe_n;
		logic [7:0] port_byte_out;
	} epp_pins_t;

	// One requested port cycle
	typedef struct packed {
		logic       is_addr;
		logic       is_write;
		logic [7:0] wbyte;
	} epp_req_t;

endpackage : epp_pkg

// ---- hdl/epp_wdog.sv ----
// Cycle watchdog counting up to the timeout limit
`timescale 1ns/1ps
module epp_wdog #(
	parameter int LIMIT = 100,
	parameter int W     = 8
) (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Control
	input  wire logic run,
	output logic      expired
);
	logic [W-1:0] cnt_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= '0;
		end else if (!run) begin
			cnt_r <= '0;
		end else if (cnt_r != W'(LIMIT)) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	assign expired = run && (cnt_r == W'(LIMIT));

endmodule : epp_wdog

// ---- hdl/epp_ahb_if.sv ----
// AHB-Lite slave front end: captures address phase valid, write and offset for the data phase
`timescale 1ns/1ps
module epp_ahb_if (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Bus
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	// Captured data phase
	output logic             dp_valid,
	output logic             dp_write,
	output logic [7:0]       dp_off
);
	import epp_pkg::*;

	wire take = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_off   <= 8'h00;
		end else if (hready) begin
			dp_valid <= take;
			dp_write <= hwrite;
			dp_off   <= haddr[7:0];
		end
	end

endmodule : epp_ahb_if

// ---- testbench/epp_periph_model.sv ----
// Behavioural peripheral on the far side of the EPP port
`timescale 1ns/1ps
module epp_periph_model (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Port from the device
	input  wire logic       data_strobe_n,
	input  wire logic       addr_strobe_n,
	input  wire logic       port_byte_oe_n,
	input  wire logic [7:0] port_byte_bus,
	// Bench control
	input  wire logic       hang,
	input  wire logic [3:0] delay,
	input  wire logic [7:0] rd_byte,
	// Port towards the device
	output logic            periph_ready_n,
	output logic [7:0]      port_byte_in,
	// Observed write
	output logic [7:0]      got_byte,
	output logic            got_addr
);
	logic [3:0] cnt_r;
	logic       drv_r;
	logic [7:0] last_r;
	wire        stb = ~data_strobe_n | ~addr_strobe_n;
	// Released bus shows the inverse of the last byte, never a stale value
	assign port_byte_in = drv_r ? rd_byte : ~last_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			periph_ready_n <= 1'b0;
			cnt_r          <= 4'h0;
			drv_r          <= 1'b0;
			last_r         <= 8'h00;
			got_byte       <= 8'h00;
			got_addr       <= 1'b0;
		end else if (stb) begin
			drv_r <= port_byte_oe_n;
			if (!port_byte_oe_n) begin
				got_byte <= port_byte_bus;
				got_addr <= ~addr_strobe_n;
			end
			if (!hang && drv_r == port_byte_oe_n && cnt_r >= delay)
				periph_ready_n <= 1'b1;
			else if (cnt_r < delay)
				cnt_r <= cnt_r + 4'h1;
		end else if (periph_ready_n) begin
			// Hold time stretches with the same delay, so back-to-back starts see ready high
			if (drv_r)
				last_r <= rd_byte;
			drv_r <= 1'b0;
			if (cnt_r == 4'h0)
				periph_ready_n <= 1'b0;
			else
				cnt_r <= cnt_r - 4'h1;
		end else begin
			cnt_r <= 4'h0;
			drv_r <= 1'b0;
		end
	end
endmodule : epp_periph_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the EPP cycle engine
`timescale 1ns/1ps
module testbench;
	import epp_pkg::*;
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] ctrl;
		logic [7:0] off;
		logic       wr;
		logic [7:0] wb;
		logic [3:0] dly;
	} epp_row_t;
	localparam int TMO = 20;
	localparam epp_row_t ROWS [8] = '{
		'{8'h01, 8'h04, EPP_OFF_DATA0, 1'b1, 8'ha5, 4'h1},
		'{8'h01, 8'h04, EPP_OFF_ADDR, 1'b1, 8'h5a, 4'h3},
		'{8'h01, 8'h04, 8'h14, 1'b0, 8'h3c, 4'h2},
		'{8'h01, 8'h04, EPP_OFF_ADDR, 1'b0, 8'hc3, 4'h1},
		'{8'h03, 8'h00, EPP_OFF_DATA3, 1'b1, 8'h81, 4'h2},
		'{8'h03, 8'h20, EPP_OFF_DATA0, 1'b0, 8'h7e, 4'h1},
		'{8'h01, 8'h05, 8'h18, 1'b0, 8'he7, 4'h1},
		'{8'h01, 8'h04, EPP_OFF_DATA0, 1'b1, 8'h00, 4'h4}};
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, hang;
	logic        ready_n, irq_in, irq_out, oe_n, ds_n, as_n, dir_n, autofd_n, sel_ctl, prst_n;
	logic        got_addr, wr_seen, rd_seen, as_seen, ds_seen, stb_was;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  delay;
	logic [7:0]  bus_in, bus_out, rd_byte, got_byte, held;
	logic [31:0] haddr, hwdata, hrdata, rdata;
	int          miscompares, checks, waits;
	epp_row_t    r;
	assign hready = hreadyout;
	epp_cycle_engine #(.TMO_CYC(TMO)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hsize(hsize), .hwrite(hwrite), .hready(hready),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.periph_ready_n(ready_n), .port_byte_in(bus_in), .periph_irq_in(irq_in),
		.err_n_in(1'b0), .slct_in(1'b1), .pe_in(1'b0), .ack_n_in(1'b1), .busy_in(1'b0),
		.port_byte_bus(bus_out), .port_byte_oe_n(oe_n), .data_strobe_n(ds_n),
		.addr_strobe_n(as_n), .xfer_dir_out_n(dir_n), .autofd_n(autofd_n),
		.printer_select_ctl(sel_ctl), .periph_reset_n(prst_n), .periph_irq_out(irq_out));
	epp_periph_model model_u (.hclk(hclk), .hresetn(hresetn), .data_strobe_n(ds_n),
		.addr_strobe_n(as_n), .port_byte_oe_n(oe_n), .port_byte_bus(bus_out), .hang(hang),
		.delay(delay), .rd_byte(rd_byte), .periph_ready_n(ready_n), .port_byte_in(bus_in),
		.got_byte(got_byte), .got_addr(got_addr));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// Master waits for the slave; only the data phase wait has a loop bound, the address phase wait has none
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		hsel <= 1'b1;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		waits = 0;
		do begin
			@(posedge hclk);
			waits++;
		end while (hreadyout !== 1'b1 && waits < 400);
		rdata = hrdata;
		chk(waits < 400, "bus stalled");
	endtask : bus
	always @(posedge hclk) begin
		// Byte on the bus in the cycle right after the strobe is released
		if (stb_was && ds_n && as_n)
			held = bus_out;
		stb_was = !ds_n || !as_n;
		if (!ds_n || !as_n) begin
			wr_seen |= (dir_n === 1'b0 && oe_n === 1'b0);
			rd_seen |= (dir_n === 1'b1 && oe_n === 1'b1);
			as_seen |= !as_n;
			ds_seen |= !ds_n;
		end
	end
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	initial begin
		#1_000_000;
		miscompares++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, hang, irq_in, delay, rd_byte} = '0;
		{wr_seen, rd_seen, as_seen, ds_seen, stb_was, held} = '0;
		hsize = 3'b010;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (ROWS[i]) begin
			r = ROWS[i];
			delay <= r.dly;
			rd_byte <= r.wb;
			bus(1'b1, EPP_OFF_MODE, {24'h0, r.mode});
			bus(1'b1, EPP_OFF_CTRL, {24'h0, r.ctrl});
			{wr_seen, rd_seen, as_seen, ds_seen} = '0;
			bus(r.wr, r.off, {24'h0, r.wb});
			chk(waits > 1, "no wait states");
			chk((r.wr | r.ctrl[0]) ? wr_seen : rd_seen, "direction");
			chk(as_seen === (r.off == EPP_OFF_ADDR), "addr strobe");
			chk(ds_seen === (r.off != EPP_OFF_ADDR), "data strobe");
			if (r.wr)
				chk(got_byte === r.wb && got_addr === as_seen, "written byte");
			else if (!r.ctrl[0])
				chk(rdata[7:0] === r.wb, "read byte");
			chk(held === r.wb || !r.wr, "byte held");
			$display("row %0d done", i);
		end
		// Disabled port refuses the access
		bus(1'b1, EPP_OFF_MODE, 32'h0);
		ds_seen = 1'b0;
		bus(1'b1, EPP_OFF_DATA0, 32'h66);
		chk(waits == 1 && !ds_seen, "disabled cycle ran");
		$display("refusal done");
		// Watchdog and both clear modes
		hang <= 1'b1;
		bus(1'b1, EPP_OFF_MODE, 32'h01);
		bus(1'b1, EPP_OFF_DATA0, 32'h11);
		chk(waits >= TMO, "early abort");
		bus(1'b0, EPP_OFF_STATUS, 32'h0);
		chk(rdata[7:0] === 8'hd1, "timeout flag set");
		bus(1'b1, EPP_OFF_STATUS, 32'h0);
		bus(1'b0, EPP_OFF_STATUS, 32'h0);
		chk(rdata[7:0] === 8'hd1, "zero write cleared");
		bus(1'b1, EPP_OFF_STATUS, 32'h1);
		bus(1'b0, EPP_OFF_STATUS, 32'h0);
		chk(rdata[7:0] === 8'hd0, "one write kept");
		bus(1'b1, EPP_OFF_MODE, 32'h11);
		bus(1'b0, EPP_OFF_ADDR, 32'h0);
		bus(1'b0, EPP_OFF_STATUS, 32'h0);
		chk(rdata[7:0] === 8'hd1, "flag lost early");
		bus(1'b0, EPP_OFF_STATUS, 32'h0);
		chk(rdata[7:0] === 8'hd0, "read clear");
		hang <= 1'b0;
		$display("timeout done");
		// Interrupt passes one clock later, uninverted
		irq_in <= 1'b1;
		@(posedge hclk);
		chk(irq_out === 1'b0, "irq early");
		@(posedge hclk);
		chk(irq_out === 1'b1, "irq lost");
		$display("irq done");
		// Second reset mid-run, then idle pins follow control
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		chk(prst_n === 1'b0 && ds_n === 1'b1 && as_n === 1'b1, "reset pins");
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b1, EPP_OFF_CTRL, 32'h2e);
		repeat (2) @(posedge hclk);
		chk(autofd_n === 1'b0 && sel_ctl === 1'b0 && oe_n === 1'b1, "idle pins");
		chk(prst_n === 1'b1 && hresp === 1'b0, "reset out");
		bus(1'b1, EPP_OFF_CTRL, 32'h04);
		bus(1'b1, EPP_OFF_DATA, 32'h96);
		repeat (2) @(posedge hclk);
		chk(oe_n === 1'b0 && bus_out === 8'h96, "idle drive");
		$display("reset done");
		tally_and_finish();
	end
endmodule : testbench
